// [verilog/scf_defines.svh]
// register offsets, field positions, reset values and timing counts
`ifndef SCF_DEFINES_SVH
`define SCF_DEFINES_SVH
`define SCF_OFS_SRC_PWR    8'h12
`define SCF_OFS_SEP_THR    8'h13
`define SCF_OFS_SCAN_POL   8'h14
`define SCF_OFS_POL_STAT   8'h15
`define SCF_OFS_SLICER     8'h16
`define SCF_OFS_PRECOAST   8'h17
`define SCF_OFS_POSTCOAST  8'h18
`define SCF_OFS_TEST_A     8'h19
`define SCF_OFS_TEST_B     8'h1a
`define SCF_OFS_GAIN_TEST  8'h1b
`define SCF_OFS_FORMAT     8'h1c
`define SCF_OFS_KEY_STAT   8'h1d
`define SCF_OFS_TEST_C     8'h1e
`define SCF_BIT_VS_OVR     3
`define SCF_BIT_VS_SEL     2
`define SCF_BIT_COAST_SEL  1
`define SCF_BIT_PWR_N      0
`define SCF_BIT_SCAN_EN    2
`define SCF_BIT_COAST_OVR  1
`define SCF_BIT_HS_OVR     0
`define SCF_BIT_HS_POL     7
`define SCF_BIT_VS_POL     6
`define SCF_BIT_COAST_POL  5
`define SCF_SLICER_MSB     7
`define SCF_SLICER_LSB     3
`define SCF_BIT_CHROMA_ORD 2
`define SCF_BIT_FMT_444    0
`define SCF_BIT_KEYS       6
`define SCF_RST_SRC_PWR    8'h01
`define SCF_RST_SEP_THR    8'h20
`define SCF_RST_SCAN_POL   8'h00
`define SCF_RST_SLICER     8'hb8
`define SCF_RST_EDGE_CNT   8'h00
`define SCF_RST_TEST       8'h00
`define SCF_RST_FORMAT     8'h01
`define SCF_CLK_MHZ        200
`define SCF_SEP_CLK_MHZ    5
`define SCF_SEP_DIV        (`SCF_CLK_MHZ / `SCF_SEP_CLK_MHZ)
`endif

// [verilog/scf_pkg.sv]
// types shared by the sync, coast and format control bank
package scf_pkg;
  typedef struct packed {
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
  } scf_pixel_t;
  typedef enum logic [1:0] { SCF_CH_HSYNC, SCF_CH_VSYNC, SCF_CH_COAST } scf_pol_ch_t;
endpackage

// [verilog/scf_regs.sv]
// sync source, coast, polarity and output format control registers
`timescale 1ns/10ps
`include "scf_defines.svh"

module scf_regs
  import scf_pkg::*;
#(
  parameter int RUN_W  = 16,
  parameter int EDGE_W = 12
) (
  input  wire logic       mclk_i,
  input  wire logic       reset_i,
  input  wire logic [7:0] reg_addr_i,
  input  wire logic       reg_wr_i,
  input  wire logic [7:0] reg_wdata_i,
  output logic [7:0]      reg_rdata_o,
  input  wire logic       hsync_i,
  input  wire logic       vsync_i,
  input  wire logic       coast_i,
  input  wire logic       csync_i,
  input  wire logic       vsync_activity_i,
  input  wire logic       keys_present_i,
  input  wire logic       hsync_pol_user_i,
  input  wire logic       coast_pol_user_i,
  input  wire logic       scan_serial_in_i,
  input  wire logic       scan_shift_clock_i,
  input  wire scf_pixel_t pix_i,
  output scf_pixel_t      pix_o,
  output logic            blue_oe_o,
  output logic            full_power_down_n_o,
  output logic            active_vsync_source_o,
  output logic            vsync_o,
  output logic            coast_o,
  output logic            hsync_pol_o,
  output logic            coast_pol_o,
  output logic            scan_en_o,
  output logic            scan_serial_out_o,
  output logic [4:0]      green_sync_thresh_o
);

  localparam logic [5:0] SEP_DIV = 6'(`SCF_SEP_DIV);

  logic [7:0]        src_pwr_reg, sep_thr_reg, scan_pol_reg, slicer_reg;
  logic [7:0]        pre_reg, post_reg, test_a_reg, test_b_reg, gain_reg;
  logic [7:0]        fmt_reg, test_c_reg;
  logic [5:0]        tick_cnt_reg;
  logic [7:0]        sep_cnt_reg;
  logic              sep_out_reg;
  logic [2:0]        pin_prev_reg, pol_reg;
  logic [RUN_W-1:0]  run_reg [3];
  logic [RUN_W-1:0]  hi_len_reg [3];
  logic [RUN_W-1:0]  lo_len_reg [3];
  logic              hs_prev_reg, csrc_prev_reg, phase_reg, sclk_prev_reg;
  logic [EDGE_W-1:0] edge_cnt_reg, frame_len_reg;
  logic [7:0]        post_cnt_reg;
  logic [23:0]       scan_shift_reg;
  logic              active_vsync_source, vsync_sel, coast_pol_eff, coast_src, pre_act, win, pwr_n;
  logic [2:0]        pins;

  function automatic logic [RUN_W-1:0] sat_inc(input logic [RUN_W-1:0] v);
    sat_inc = (&v) ? v : v + 1'b1;
  endfunction

  // register writes from the serial port back end
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      src_pwr_reg  <= `SCF_RST_SRC_PWR;
      sep_thr_reg  <= `SCF_RST_SEP_THR;
      scan_pol_reg <= `SCF_RST_SCAN_POL;
      slicer_reg   <= `SCF_RST_SLICER;
      pre_reg      <= `SCF_RST_EDGE_CNT;
      post_reg     <= `SCF_RST_EDGE_CNT;
      test_a_reg   <= `SCF_RST_TEST;
      test_b_reg   <= `SCF_RST_TEST;
      gain_reg     <= `SCF_RST_TEST;
      fmt_reg      <= `SCF_RST_FORMAT;
      test_c_reg   <= `SCF_RST_TEST;
    end
    else if (reg_wr_i)
    begin
      case (reg_addr_i)
        `SCF_OFS_SRC_PWR:   src_pwr_reg  <= reg_wdata_i;
        `SCF_OFS_SEP_THR:   sep_thr_reg  <= reg_wdata_i;
        `SCF_OFS_SCAN_POL:  scan_pol_reg <= reg_wdata_i;
        `SCF_OFS_SLICER:    slicer_reg   <= reg_wdata_i;
        `SCF_OFS_PRECOAST:  pre_reg      <= reg_wdata_i;
        `SCF_OFS_POSTCOAST: post_reg     <= reg_wdata_i;
        `SCF_OFS_TEST_A:    test_a_reg   <= reg_wdata_i;
        `SCF_OFS_TEST_B:    test_b_reg   <= reg_wdata_i;
        `SCF_OFS_GAIN_TEST: gain_reg     <= reg_wdata_i;
        `SCF_OFS_FORMAT:    fmt_reg      <= reg_wdata_i;
        `SCF_OFS_TEST_C:    test_c_reg   <= reg_wdata_i;
        default:            ;
      endcase
    end
  end

  // registered read mux, unmapped offsets read zero
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
      reg_rdata_o <= 8'h00;
    else
    begin
      case (reg_addr_i)
        `SCF_OFS_SRC_PWR:   reg_rdata_o <= src_pwr_reg;
        `SCF_OFS_SEP_THR:   reg_rdata_o <= sep_thr_reg;
        `SCF_OFS_SCAN_POL:  reg_rdata_o <= scan_pol_reg;
        `SCF_OFS_POL_STAT:  reg_rdata_o <= {pol_reg[0], pol_reg[1], pol_reg[2], 5'h00};
        `SCF_OFS_SLICER:    reg_rdata_o <= slicer_reg;
        `SCF_OFS_PRECOAST:  reg_rdata_o <= pre_reg;
        `SCF_OFS_POSTCOAST: reg_rdata_o <= post_reg;
        `SCF_OFS_TEST_A:    reg_rdata_o <= test_a_reg;
        `SCF_OFS_TEST_B:    reg_rdata_o <= test_b_reg;
        `SCF_OFS_GAIN_TEST: reg_rdata_o <= gain_reg;
        `SCF_OFS_FORMAT:    reg_rdata_o <= fmt_reg;
        `SCF_OFS_KEY_STAT:  reg_rdata_o <= {1'b0, keys_present_i, 6'h00};
        `SCF_OFS_TEST_C:    reg_rdata_o <= test_c_reg;
        default:            reg_rdata_o <= 8'h00;
      endcase
    end
  end

  // source selection; activity unseen while powered down
  always_comb
  begin
    pwr_n = src_pwr_reg[`SCF_BIT_PWR_N];
    active_vsync_source = src_pwr_reg[`SCF_BIT_VS_OVR] ? src_pwr_reg[`SCF_BIT_VS_SEL]
                                       : ~(vsync_activity_i & pwr_n);
    vsync_sel = active_vsync_source ? sep_out_reg : vsync_i;
    coast_pol_eff = scan_pol_reg[`SCF_BIT_COAST_OVR] ? coast_pol_user_i : pol_reg[2];
    coast_src = src_pwr_reg[`SCF_BIT_COAST_SEL] ? (vsync_sel ~^ pol_reg[1])
                                                : (coast_i ~^ coast_pol_eff);
    pins = {coast_i, vsync_sel, hsync_i};
  end

  // sync separator on a 5 MHz tick
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      tick_cnt_reg <= 6'h00;
      sep_cnt_reg  <= 8'h00;
      sep_out_reg  <= 1'b0;
    end
    else
    begin
      tick_cnt_reg <= (tick_cnt_reg == SEP_DIV - 6'h01) ? 6'h00 : tick_cnt_reg + 6'h01;
      if (tick_cnt_reg == SEP_DIV - 6'h01)
      begin
        if (csync_i == sep_out_reg)
          sep_cnt_reg <= 8'h00;
        else if (sep_cnt_reg + 8'h01 >= sep_thr_reg)
        begin
          sep_out_reg <= csync_i;
          sep_cnt_reg <= 8'h00;
        end
        else
          sep_cnt_reg <= sep_cnt_reg + 8'h01;
      end
    end
  end

  // polarity detection: the shorter level is the pulse
  always_ff @(posedge mclk_i)
  begin
    if (reset_i || !pwr_n)
    begin
      pin_prev_reg <= 3'h0;
      pol_reg      <= 3'h0;
      for (int i = 0; i < 3; i++)
      begin
        run_reg[i]    <= '0;
        hi_len_reg[i] <= '0;
        lo_len_reg[i] <= '0;
      end
    end
    else
    begin
      pin_prev_reg <= pins;
      for (int i = 0; i < 3; i++)
      begin
        if (pins[i] != pin_prev_reg[i])
        begin
          run_reg[i] <= '0;
          if (pin_prev_reg[i])
            hi_len_reg[i] <= run_reg[i];
          else
            lo_len_reg[i] <= run_reg[i];
        end
        else
          run_reg[i] <= sat_inc(run_reg[i]);
        pol_reg[i] <= hi_len_reg[i] < lo_len_reg[i];
      end
    end
  end

  // precoast from last frame length, postcoast by edge countdown
  always_comb
  begin
    pre_act = (frame_len_reg != '0) && (pre_reg != 8'h00)
              && ((EDGE_W+1)'(edge_cnt_reg) + (EDGE_W+1)'(pre_reg)
                  >= (EDGE_W+1)'(frame_len_reg));
    // the fall cycle itself is covered before the countdown is loaded
    win = coast_src | pre_act | (post_cnt_reg != 8'h00)
          | (csrc_prev_reg && post_reg != 8'h00);
  end

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      hs_prev_reg   <= 1'b0;
      csrc_prev_reg <= 1'b0;
      edge_cnt_reg  <= '0;
      frame_len_reg <= '0;
      post_cnt_reg  <= 8'h00;
    end
    else
    begin
      hs_prev_reg   <= hsync_i;
      csrc_prev_reg <= coast_src;
      if (coast_src && !csrc_prev_reg)
      begin
        frame_len_reg <= edge_cnt_reg;
        edge_cnt_reg  <= '0;
      end
      else if (hsync_i && !hs_prev_reg && !(&edge_cnt_reg))
        edge_cnt_reg <= edge_cnt_reg + 1'b1;
      if (!coast_src && csrc_prev_reg)
        post_cnt_reg <= post_reg;
      else if (hsync_i && !hs_prev_reg && post_cnt_reg != 8'h00)
        post_cnt_reg <= post_cnt_reg - 8'h01;
    end
  end

  // control and sync outputs
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      full_power_down_n_o   <= 1'b1;
      active_vsync_source_o <= 1'b0;
      vsync_o               <= 1'b0;
      coast_o               <= 1'b0;
      hsync_pol_o           <= 1'b0;
      coast_pol_o           <= 1'b0;
      scan_en_o             <= 1'b0;
      green_sync_thresh_o   <= 5'h00;
    end
    else
    begin
      full_power_down_n_o   <= pwr_n;
      active_vsync_source_o <= active_vsync_source;
      vsync_o               <= vsync_sel;
      coast_o               <= coast_pol_eff ? win : ~win;
      hsync_pol_o           <= scan_pol_reg[`SCF_BIT_HS_OVR] ? hsync_pol_user_i
                                                              : pol_reg[0];
      coast_pol_o           <= coast_pol_eff;
      scan_en_o             <= scan_pol_reg[`SCF_BIT_SCAN_EN];
      green_sync_thresh_o   <= slicer_reg[`SCF_SLICER_MSB:`SCF_SLICER_LSB];
    end
  end

  // scan chain shifted on rising scan clock while enabled
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      sclk_prev_reg     <= 1'b0;
      scan_shift_reg    <= 24'h000000;
      scan_serial_out_o <= 1'b0;
    end
    else
    begin
      sclk_prev_reg <= scan_shift_clock_i;
      if (scan_pol_reg[`SCF_BIT_SCAN_EN] && scan_shift_clock_i && !sclk_prev_reg)
        scan_shift_reg <= {scan_shift_reg[22:0], scan_serial_in_i};
      scan_serial_out_o <= scan_shift_reg[23];
    end
  end

  // pixel output formatter
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      phase_reg <= 1'b0;
      pix_o     <= '0;
      blue_oe_o <= 1'b0;
    end
    else
    begin
      phase_reg <= ~phase_reg;
      if (scan_pol_reg[`SCF_BIT_SCAN_EN])
      begin
        pix_o     <= scan_shift_reg;
        blue_oe_o <= 1'b1;
      end
      else if (!pwr_n)
      begin
        pix_o     <= '0;
        blue_oe_o <= 1'b0;
      end
      else if (fmt_reg[`SCF_BIT_FMT_444])
      begin
        pix_o     <= pix_i;
        blue_oe_o <= 1'b1;
      end
      else
      begin
        pix_o.green <= pix_i.green;
        pix_o.red   <= (phase_reg == 1'b0) == fmt_reg[`SCF_BIT_CHROMA_ORD]
                       ? pix_i.red : pix_i.blue;
        pix_o.blue  <= 8'h00;
        blue_oe_o   <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);

  chk_vsync_override: assert property (src_pwr_reg[`SCF_BIT_VS_OVR]
    |=> active_vsync_source_o == $past(src_pwr_reg[`SCF_BIT_VS_SEL]))
    else $error("active vsync status not forced by override");
  chk_vsync_route: assert property (!$past(reset_i) |->
    vsync_o == ($past(active_vsync_source) ? $past(sep_out_reg) : $past(vsync_i)))
    else $error("vsync output from wrong source");
  chk_power_pin: assert property (reg_wr_i && reg_addr_i == `SCF_OFS_SRC_PWR
    |=> ##1 full_power_down_n_o == $past(reg_wdata_i[0], 2))
    else $error("power down output does not follow register");
  chk_sep_hold: assert property ($changed(sep_out_reg)
    |-> $past(tick_cnt_reg) == SEP_DIV - 6'h01)
    else $error("separator toggled off tick");
  chk_scan_en: assert property (scan_pol_reg[`SCF_BIT_SCAN_EN]
    |=> scan_en_o)
    else $error("scan enable not driven");
  chk_hs_pol_user: assert property (scan_pol_reg[`SCF_BIT_HS_OVR]
    |=> hsync_pol_o == $past(hsync_pol_user_i))
    else $error("hsync polarity override ignored");
  chk_coast_pol: assert property (!$past(reset_i) |-> coast_pol_o == $past(coast_pol_eff))
    else $error("coast polarity source wrong");
  chk_slicer_out: assert property (reg_wr_i && reg_addr_i == `SCF_OFS_SLICER
    |=> ##1 green_sync_thresh_o == $past(reg_wdata_i[7:3], 2))
    else $error("slicer threshold not passed through");
  chk_post_hold: assert property (!coast_src && csrc_prev_reg && post_reg != 8'h00
    |-> win ##1 win)
    else $error("postcoast window missing");
  chk_blue_release: assert property (pwr_n && !scan_pol_reg[`SCF_BIT_SCAN_EN]
    && !fmt_reg[`SCF_BIT_FMT_444] |=> !blue_oe_o)
    else $error("blue driven in 4:2:2");
  chk_coast_window: assert property (!$past(reset_i) |-> coast_o == ($past(coast_pol_eff)
    ? $past(win) : !$past(win)))
    else $error("coast output mismatch");

  cov_sep_toggle: cover property ($rose(sep_out_reg));
  cov_mode_422:   cover property (!blue_oe_o && full_power_down_n_o);
  cov_precoast:   cover property (pre_act && !coast_src);
  cov_scan_shift: cover property (scan_en_o && $changed(scan_serial_out_o));

endmodule // scf_regs

// [testbench/scf_host_model.sv]
// host model driving the register bank's parallel access port
`timescale 1ns/10ps
module scf_host_model (
  input  wire logic       mclk_i,
  input  wire logic [7:0] reg_rdata_i,
  output logic [7:0]      reg_addr_o,
  output logic            reg_wr_o,
  output logic [7:0]      reg_wdata_o
);
  // idle bus at time zero
  initial
  begin
    reg_addr_o  = 8'h00;
    reg_wr_o    = 1'b0;
    reg_wdata_o = 8'h00;
  end

  // one-cycle strobe, data inverted once released
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    reg_addr_o  <= a;
    reg_wdata_o <= d;
    reg_wr_o    <= 1'b1;
    @(posedge mclk_i);
    reg_wr_o    <= 1'b0;
    reg_wdata_o <= ~d;
    repeat (2) @(posedge mclk_i);
  endtask

  // address held, data taken one edge after it lands
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk_i);
    reg_addr_o <= a;
    repeat (2) @(posedge mclk_i);
    #1 d = reg_rdata_i;
  endtask

  // settings the bank needs for proper operation
  task automatic init;
    wr(8'h1a, 8'h41);
    wr(8'h1e, 8'hff);
    wr(8'h1b, 8'h00);
    wr(8'h1c, 8'h01);
  endtask
endmodule // scf_host_model

// [testbench/test_sync_coast_format_control_regs.sv]
// self-checking bench for the sync, coast and format control bank
`timescale 1ns/10ps
module test_sync_coast_format_control_regs;
  import scf_pkg::*;
  localparam logic [23:0] SCAN_PAT = 24'ha5c396;
  logic        mclk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic [7:0]  reg_addr_i, reg_wdata_i, reg_rdata_o, rd_val;
  logic        reg_wr_i;
  logic        hsync_i = 1'b0, vsync_i = 1'b0, coast_i = 1'b0, csync_i = 1'b0;
  logic        vsync_activity_i = 1'b1, keys_present_i = 1'b1;
  logic        hsync_pol_user_i = 1'b0, coast_pol_user_i = 1'b0;
  logic        scan_serial_in_i = 1'b0, scan_shift_clock_i = 1'b0;
  scf_pixel_t  pix_i = 24'h112233; // luma on green
  scf_pixel_t  pix_o;
  logic        blue_oe_o, full_power_down_n_o, active_vsync_source_o;
  logic        vsync_o, coast_o, hsync_pol_o, coast_pol_o;
  logic        scan_en_o, scan_serial_out_o;
  logic [4:0]  green_sync_thresh_o;
  logic [15:0] red_seen;
  int          fail_count = 0;
  int          check_count = 0;
  int          cycles = 0;
  logic [15:0] rst_tab [13] = '{16'h1201, 16'h1320, 16'h1400, 16'h16b8,
    16'h1700, 16'h1800, 16'h1900, 16'h1a00, 16'h1b00, 16'h1c01, 16'h1d40,
    16'h1f00, 16'h3f00};

  scf_regs DUT (
    .mclk_i, .reset_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_rdata_o,
    .hsync_i, .vsync_i, .coast_i, .csync_i, .vsync_activity_i,
    .keys_present_i, .hsync_pol_user_i, .coast_pol_user_i,
    .scan_serial_in_i, .scan_shift_clock_i, .pix_i, .pix_o, .blue_oe_o,
    .full_power_down_n_o, .active_vsync_source_o, .vsync_o, .coast_o,
    .hsync_pol_o, .coast_pol_o, .scan_en_o, .scan_serial_out_o,
    .green_sync_thresh_o
  );

  scf_host_model host (
    .mclk_i      (mclk_i),
    .reg_rdata_i (reg_rdata_o),
    .reg_addr_o  (reg_addr_i),
    .reg_wr_o    (reg_wr_i),
    .reg_wdata_o (reg_wdata_i)
  );

  // 200 MHz clock
  always #2.5 mclk_i = ~mclk_i;

  // hang guard
  always @(posedge mclk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      close_out;
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("Error at %0t ns seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    host.rd(a, rd_val);
    chk(rd_val, e);
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask

  // four periods of hi high cycles then lo low cycles on the hsync, vsync and coast pins
  task automatic runs(input int hi, input int lo);
    repeat (4)
    begin
      repeat (hi) @(posedge mclk_i) {hsync_i, vsync_i, coast_i} <= 3'b111;
      repeat (lo) @(posedge mclk_i) {hsync_i, vsync_i, coast_i} <= 3'b000;
    end
    wait_n(2);
  endtask

  // red lane over one pair; even cycle counts carry the pair's first half
  task automatic red_pair;
    wait_n(1);
    if (cycles % 2 != 0)
      wait_n(1);
    red_seen[15:8] = pix_o.red;
    wait_n(1);
    red_seen[7:0] = pix_o.red;
  endtask

  task automatic scan_bit(input logic b);
    @(posedge mclk_i) scan_serial_in_i <= b;
    repeat (2) @(posedge mclk_i) scan_shift_clock_i <= 1'b1;
    repeat (2) @(posedge mclk_i) scan_shift_clock_i <= 1'b0;
  endtask

  // main sequence
  initial
  begin
    repeat (3) @(posedge mclk_i);
    reset_i <= 1'b0;
    wait_n(1);
    chk(green_sync_thresh_o, 5'd23);
    chk(full_power_down_n_o, 1'b1);
    chk(scan_en_o, 1'b0);
    foreach (rst_tab[i])
      rchk(rst_tab[i][15:8], rst_tab[i][7:0]);
    // round trip, read-only place ignores writes
    host.wr(8'h17, 8'h5a);
    host.wr(8'h18, 8'ha5);
    host.wr(8'h1d, 8'hff);
    rchk(8'h17, 8'h5a);
    rchk(8'h18, 8'ha5);
    rchk(8'h1d, 8'h40);
    @(posedge mclk_i) keys_present_i <= 1'b0;
    rchk(8'h1d, 8'h00);
    host.init;
    host.wr(8'h16, 8'h28);
    chk(green_sync_thresh_o, 5'd5);
    // vsync source automatic, then forced
    host.wr(8'h12, 8'h01);
    chk(active_vsync_source_o, 1'b0);
    @(posedge mclk_i) vsync_activity_i <= 1'b0;
    wait_n(3);
    chk(active_vsync_source_o, 1'b1);
    host.wr(8'h12, 8'h09);
    chk(active_vsync_source_o, 1'b0);
    // full power-down
    host.wr(8'h12, 8'h08);
    chk({full_power_down_n_o, pix_o}, 25'h0);
    host.wr(8'h12, 8'h09);
    // polarity detection and user override
    runs(3, 9);
    rchk(8'h15, 8'he0);
    chk({hsync_pol_o, coast_pol_o}, 2'b11);
    host.wr(8'h14, 8'h03);
    chk({hsync_pol_o, coast_pol_o}, 2'b00);
    runs(9, 3);
    rchk(8'h15, 8'h00);
    @(posedge mclk_i) {hsync_pol_user_i, coast_pol_user_i} <= 2'b11;
    wait_n(3);
    chk({hsync_pol_o, coast_pol_o}, 2'b11);
    host.wr(8'h14, 8'h00);
    chk({hsync_pol_o, coast_pol_o}, 2'b00);
    // separator recovers vsync from composite sync
    host.wr(8'h13, 8'h02);
    host.wr(8'h12, 8'h0d);
    chk(active_vsync_source_o, 1'b1);
    @(posedge mclk_i) csync_i <= 1'b1;
    wait_n(20);
    chk(vsync_o, 1'b0);
    wait_n(150);
    chk(vsync_o, 1'b1);
    host.wr(8'h12, 8'h09);
    chk(vsync_o, 1'b0);
    // 4:2:2 chroma on red, blue released
    host.wr(8'h1c, 8'h04);
    red_pair;
    chk(red_seen, 16'h1133);
    host.wr(8'h1c, 8'h00);
    red_pair;
    chk(red_seen, 16'h3311);
    chk({pix_o.green, pix_o.blue, blue_oe_o}, 17'h04400);
    host.wr(8'h1c, 8'h01);
    chk({pix_o, blue_oe_o}, {24'h112233, 1'b1});
    // scan chain loads the outputs
    host.wr(8'h14, 8'h04);
    chk(scan_en_o, 1'b1);
    for (int i = 23; i >= 0; i--)
      scan_bit(SCAN_PAT[i]);
    wait_n(3);
    chk({pix_o, scan_serial_out_o}, {SCAN_PAT, 1'b1});
    host.wr(8'h14, 8'h00);
    chk(pix_o, 24'h112233);
    // postcoast holds coast for two hsync rising edges after the source ends
    host.wr(8'h17, 8'h00);
    host.wr(8'h18, 8'h02);
    host.wr(8'h14, 8'h02);
    wait_n(1);
    chk({coast_o, coast_pol_o}, 2'b11);
    repeat (2) @(posedge mclk_i) hsync_i <= ~hsync_i;
    wait_n(2);
    chk(coast_o, 1'b1);
    repeat (2) @(posedge mclk_i) hsync_i <= ~hsync_i;
    wait_n(2);
    chk(coast_o, 1'b0);
    close_out;
  end
endmodule // test_sync_coast_format_control_regs
